// File: sim/tb.sv
// Self-checking bench for the receive tuning configuration bank
`timescale 1ns/1ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // Clock, reset and design signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic short_sel = 1'b0;
  logic [7:0] energy = 8'h00;
  logic [7:0] floor_lvl = 8'h00;
  logic [7:0] strength = 8'h00;
  logic run = 1'b0;
  logic pvalid = 1'b0;
  logic [7:0] peak = 8'h00;
  logic [1:0] phase = 2'h3;
  logic [7:0] rdata;
  logic [6:0] seed_out;
  logic [6:0] wthr;
  logic wabs;
  logic ed;
  logic ant;
  logic dbl;
  logic [5:0] lead;
  logic [5:0] lag;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int regs[12];
  int fl, re, ra, lv, sv, el, eg, sum, pv;
  int unsigned seed;

  rx_tuning_config_regs dut_u (
    .CLOCK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WR_DATA_IN(wdata),
    .WR_STROBE_IN(wr_en), .RD_STROBE_IN(rd_en), .RD_DATA_OUT(rdata),
    .PREAMBLE_SHORT_IN(short_sel), .SCRAMBLER_SEED_OUT(seed_out),
    .WEIGHT_THRESHOLD_OUT(wthr), .WEIGHT_ABSOLUTE_OUT(wabs),
    .ENERGY_LEVEL_IN(energy), .NOISE_FLOOR_IN(floor_lvl),
    .ENERGY_DETECT_OUT(ed), .STRENGTH_IN(strength),
    .ANTENNA_SEARCH_OUT(ant), .FILTER_RUN_IN(run),
    .PEAK_VALID_IN(pvalid), .PEAK_VALUE_IN(peak), .GAIN_DOUBLE_OUT(dbl),
    .PACKET_PHASE_IN(phase), .LEAD_COEF_OUT(lead), .LAG_COEF_OUT(lag)
  );

  // Free-running 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  // Hang guard: far above the roughly 670 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Helpers and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Coefficient codes above 32 are clamped; bits 7:6 carry nothing
  function automatic int sat(input int v);
    return ((v & 63) > 32) ? 32 : (v & 63);
  endfunction : sat

  function automatic int clamp8(input int v);
    return (v < 0) ? 0 : (v > 255) ? 255 : v;
  endfunction : clamp8

  // Reset is seen high at exactly two edges; callers return just after one
  task automatic do_reset;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) regs[i] = 0;
  endtask : do_reset

  // Writes to unmapped places leave the model untouched as well
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    if (a >= 8'h46 && a <= 8'h5c && !a[0]) regs[(a - 8'h46) / 2] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Write then read one mapped byte with no idle cycle between strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    regs[(a - 8'h46) / 2] = d;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    q = rdata;
  endtask : wr_rd

  // Level outputs lag their causes by two edges at most
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [7:0] ra8(input int i);
    return 8'(8'h46 + 2 * i);
  endfunction : ra8

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    seed = $urandom(32'hb425);
    do_reset();
    // Reset contents, random fill, unmapped write and read, readback
    for (int i = 0; i < 12; i++) begin
      rd(ra8(i), d);
      check(16'(d), 16'h0000);
    end
    for (int i = 0; i < 12; i++) wr(ra8(i), 8'($urandom));
    wr(8'h47, 8'hff);
    rd(8'h47, d);
    check(16'(d), 16'h0000);
    for (int i = 0; i < 12; i++) begin
      rd(ra8(i), d);
      check(16'(d), 16'(regs[i]));
    end
    // Weight threshold mode bit and the two recommended settings
    for (int k = 0; k < 3; k++) begin
      wr(8'h46, (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : 8'($urandom));
      settle();
      check(16'({wabs, wthr}), 16'(regs[0]));
    end
    // Seed choice follows the preamble select; fresh seed in the chosen one
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      short_sel <= s[0];
      wr(ra8(1 + s % 2), 8'($urandom));
      settle();
      check(16'(seed_out), 16'(regs[1 + s % 2] & 127));
    end
    // Energy and antenna compares, half of them near the boundary
    for (int t = 0; t < 40; t++) begin
      wr(8'h4c, 8'($urandom));
      wr(8'h50, 8'($urandom));
      fl = int'($urandom % 256);
      re = regs[3][7] ? (regs[3] & 127) : fl + (regs[3] & 127);
      ra = regs[5][7] ? (regs[5] & 127) : fl + (regs[5] & 127);
      lv = clamp8(t[0] ? re - 1 + int'($urandom % 2) : int'($urandom % 256));
      sv = clamp8(t[0] ? ra - 1 + int'($urandom % 2) : int'($urandom % 256));
      @(posedge clk);
      floor_lvl <= 8'(fl);
      energy <= 8'(lv);
      strength <= 8'(sv);
      settle();
      check(16'(ed), 16'(lv >= re));
      check(16'(ant), 16'(sv < ra));
    end
    // Coefficient pair per phase; idle keeps the last pair
    for (int r = 0; r < 4; r++) begin
      for (int i = 6; i < 12; i++)
        wr(ra8(i), (r == 0) ? 8'h20 : (r == 1) ? 8'hff : 8'($urandom));
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        phase <= 2'(p);
        settle();
        if (p < 3) begin
          el = sat(regs[6 + 2 * p]);
          eg = sat(regs[7 + 2 * p]);
        end
        check(16'(lead), 16'(el));
        check(16'(lag), 16'(eg));
      end
    end
    // Gain doubling: disabled, headroom, exact sum, random
    for (int g = 0; g < 5; g++) begin
      wr(8'h4e, (g == 0) ? 8'h00 : (g == 1) ? 8'hff : (g == 2) ? 8'h80 :
         (g == 3) ? 8'h81 : 8'($urandom));
      @(posedge clk);
      run <= 1'b1;
      @(posedge clk);
      sum = 0;
      for (int k = 0; k < 8; k++) begin
        pv = (g == 4) ? int'($urandom % 64) : (g < 2) ? 1 : 16;
        sum += pv;
        @(posedge clk);
        pvalid <= 1'b1;
        peak <= 8'(pv);
      end
      @(posedge clk);
      pvalid <= 1'b0;
      settle();
      check(16'(dbl), 16'(regs[4] != 0 && sum < regs[4]));
      @(posedge clk);
      run <= 1'b0;
      settle();
      check(16'(dbl), 16'h0000);
    end
    // Back-to-back write and read keep the whole byte
    for (int i = 0; i < 4; i++) begin
      wr_rd(8'h52, 8'($urandom), d);
      check(16'(d), 16'(regs[6]));
    end
    // Reset in mid-run clears stored contents
    wr(8'h52, 8'h3c);
    do_reset();
    rd(8'h52, d);
    check(16'(d), 16'h0000);
    give_verdict();
  end
endmodule : tb

`default_nettype wire

// File: src/gain_scale_check.sv
// Eight-peak accumulation and gain doubling decision
`timescale 1ns/1ps
`default_nettype none

module gain_scale_check (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Filter activity and peaks
  input wire logic run_in,
  input wire logic peak_valid_in,
  input wire logic [7:0] peak_in,
  input wire logic [7:0] threshold_in,
  // Decision
  output logic double_out
);

  rx_tuning_pkg::gain_state_s q;
  rx_tuning_pkg::gain_state_s next_q;
  logic [10:0] sum_new;

  // Accumulate peaks; decide on the eighth, hold until the filter stops
  always_comb begin
    next_q = q;
    sum_new = q.sum + {3'b000, peak_in};
    unique case (q.st)
      rx_tuning_pkg::GAIN_IDLE: begin
        next_q.count = 3'h0;
        next_q.sum = 11'h000;
        next_q.double_gain = 1'b0;
        if (run_in) begin
          next_q.st = rx_tuning_pkg::GAIN_ACCUM;
        end
      end
      rx_tuning_pkg::GAIN_ACCUM: begin
        if (!run_in) begin
          next_q.st = rx_tuning_pkg::GAIN_IDLE;
        end else if (peak_valid_in) begin
          next_q.sum = sum_new;
          next_q.count = q.count + 3'h1;
          if (q.count == `RXT_LAST_PEAK) begin
            next_q.st = rx_tuning_pkg::GAIN_DONE;
            // Zero threshold blocks doubling outright
            next_q.double_gain = (threshold_in != 8'h00) &&
                                 (sum_new < {3'b000, threshold_in});
          end
        end
      end
      rx_tuning_pkg::GAIN_DONE: begin
        if (!run_in) begin
          next_q.st = rx_tuning_pkg::GAIN_IDLE;
          next_q.double_gain = 1'b0;
        end
      end
      default: begin
        next_q.st = rx_tuning_pkg::GAIN_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign double_out = q.double_gain;

  sequence s_last_peak;
    q.st == rx_tuning_pkg::GAIN_ACCUM && run_in && peak_valid_in &&
      q.count == `RXT_LAST_PEAK;
  endsequence

  property p_decide_on_eighth;
    @(posedge clk_in) disable iff (rst_in)
    s_last_peak |=> q.st == rx_tuning_pkg::GAIN_DONE;
  endproperty
  a_decide_on_eighth: assert property (p_decide_on_eighth)
    else $error("gain decision not taken on eighth peak");

  property p_zero_never_doubles;
    @(posedge clk_in) disable iff (rst_in)
    s_last_peak and threshold_in == 8'h00 |=> !double_out;
  endproperty
  a_zero_never_doubles: assert property (p_zero_never_doubles)
    else $error("gain doubled with zero threshold");

endmodule : gain_scale_check

`default_nettype wire

// File: src/level_cmp_if.sv
// Threshold comparison carrier between the bank and a comparator
`timescale 1ns/1ps
`default_nettype none

interface level_cmp_if;
  logic absolute;
  logic [6:0] threshold;
  logic [7:0] floor;
  logic [7:0] level;
  logic above;
  logic below;
  modport cfg (output absolute, threshold, floor, level, input above, below);
  modport cmp (input absolute, threshold, floor, level, output above, below);
endinterface : level_cmp_if

`default_nettype wire

// File: src/level_compare.sv
// Registered comparison of a level against a relative or absolute threshold
`timescale 1ns/1ps
`default_nettype none

module level_compare (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Comparison carrier
  level_cmp_if.cmp port
);

  rx_tuning_pkg::cmp_state_s q;
  rx_tuning_pkg::cmp_state_s next_q;
  logic [8:0] ref_level;
  logic [8:0] level9;

  // Reference is floor plus threshold, or the threshold alone
  always_comb begin
    level9 = {1'b0, port.level};
    ref_level = port.absolute ? {2'b00, port.threshold} :
                {1'b0, port.floor} + {2'b00, port.threshold};
    next_q.above = level9 >= ref_level;
    next_q.below = level9 < ref_level;
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign port.above = q.above;
  assign port.below = q.below;

  // Absolute mode ignores the floor entirely
  property p_absolute_hit;
    @(posedge clk_in) disable iff (rst_in)
    port.absolute && ({1'b0, port.level} >= {2'b00, port.threshold})
      |=> port.above && !port.below;
  endproperty
  a_absolute_hit: assert property (p_absolute_hit)
    else $error("absolute threshold crossing missed");

endmodule : level_compare

`default_nettype wire

// File: src/rx_tuning_config_regs.sv
// Receive tuning configuration bank with seed, threshold and loop logic
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rx_tuning_defs.svh"

module rx_tuning_config_regs (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  // Register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic WR_STROBE_IN,
  input wire logic RD_STROBE_IN,
  output logic [7:0] RD_DATA_OUT,
  // Preamble seed
  input wire logic PREAMBLE_SHORT_IN,
  output logic [6:0] SCRAMBLER_SEED_OUT,
  // Matched filter weights
  output logic [6:0] WEIGHT_THRESHOLD_OUT,
  output logic WEIGHT_ABSOLUTE_OUT,
  // Energy detect
  input wire logic [7:0] ENERGY_LEVEL_IN,
  input wire logic [7:0] NOISE_FLOOR_IN,
  output logic ENERGY_DETECT_OUT,
  // Antenna search
  input wire logic [7:0] STRENGTH_IN,
  output logic ANTENNA_SEARCH_OUT,
  // Matched filter gain scaling
  input wire logic FILTER_RUN_IN,
  input wire logic PEAK_VALID_IN,
  input wire logic [7:0] PEAK_VALUE_IN,
  output logic GAIN_DOUBLE_OUT,
  // Tracking loop
  input wire logic [1:0] PACKET_PHASE_IN,
  output logic [5:0] LEAD_COEF_OUT,
  output logic [5:0] LAG_COEF_OUT
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int NUM_REGS = `RXT_NUM_REGS;
  // Address table, index 0 at the low end
  localparam logic [NUM_REGS-1:0][7:0] REG_ADDR = {
    `RXT_ADDR_DATA_LAG, `RXT_ADDR_DATA_LEAD,
    `RXT_ADDR_HDR_LAG, `RXT_ADDR_HDR_LEAD,
    `RXT_ADDR_PRE_LAG, `RXT_ADDR_PRE_LEAD,
    `RXT_ADDR_ANTENNA_THR, `RXT_ADDR_GAIN_THR,
    `RXT_ADDR_ENERGY_THR, `RXT_ADDR_SHORT_SEED,
    `RXT_ADDR_LONG_SEED, `RXT_ADDR_WEIGHT_THR
  };

  rx_tuning_pkg::cfg_state_s q;
  rx_tuning_pkg::cfg_state_s next_q;
  rx_tuning_pkg::packet_phase_e phase;
  logic [NUM_REGS-1:0] hit;
  logic any_hit;
  logic [3:0] hit_idx;

  level_cmp_if energy_if ();
  level_cmp_if antenna_if ();

  // Codes above 100000 would exceed four; saturate rather than wrap
  function automatic logic [5:0] clamp_coef(input logic [7:0] r);
    logic [5:0] c;
    c = r[5:0];
    if (c > `RXT_COEF_MAX) begin
      c = `RXT_COEF_MAX;
    end
    return c;
  endfunction : clamp_coef

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // One comparator per register
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_decode
      assign hit[gi] = ADDR_IN == REG_ADDR[gi];
    end
  endgenerate

  assign any_hit = |hit;

  // Encode the single hit into a storage index
  always_comb begin
    hit_idx = 4'h0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (hit[i]) begin
        hit_idx = 4'(i);
      end
    end
  end

  // Phase from the same-clock receive sequencer, so no synchroniser
  assign phase = rx_tuning_pkg::packet_phase_e'(PACKET_PHASE_IN);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Register writes, one-cycle read data, seed and coefficient selection
  always_comb begin
    next_q = q;
    // Read data stands for one cycle only, zero otherwise
    next_q.rd_data = 8'h00;
    if (WR_STROBE_IN && any_hit) begin
      // Whole byte kept, upper bits included
      next_q.cfg[hit_idx] = WR_DATA_IN;
    end
    if (RD_STROBE_IN && any_hit) begin
      next_q.rd_data = q.cfg[hit_idx];
    end
    // Short select takes the short seed, else the long one
    if (PREAMBLE_SHORT_IN) begin
      next_q.seed = q.cfg[`RXT_IDX_SHORT_SEED][6:0];
    end else begin
      next_q.seed = q.cfg[`RXT_IDX_LONG_SEED][6:0];
    end
    // Idle keeps the last pair so the loop does not jump between packets
    unique case (phase)
      rx_tuning_pkg::PHASE_PREAMBLE: begin
        next_q.lead = clamp_coef(q.cfg[`RXT_IDX_PRE_LEAD]);
        next_q.lag = clamp_coef(q.cfg[`RXT_IDX_PRE_LAG]);
      end
      rx_tuning_pkg::PHASE_HEADER: begin
        next_q.lead = clamp_coef(q.cfg[`RXT_IDX_HDR_LEAD]);
        next_q.lag = clamp_coef(q.cfg[`RXT_IDX_HDR_LAG]);
      end
      rx_tuning_pkg::PHASE_DATA: begin
        next_q.lead = clamp_coef(q.cfg[`RXT_IDX_DATA_LEAD]);
        next_q.lag = clamp_coef(q.cfg[`RXT_IDX_DATA_LAG]);
      end
      rx_tuning_pkg::PHASE_IDLE: begin
        next_q.lead = q.lead;
        next_q.lag = q.lag;
      end
    endcase
  end

  // State register
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs and helpers
  // ----------------------------------------------------------------------
  assign RD_DATA_OUT = q.rd_data;
  assign SCRAMBLER_SEED_OUT = q.seed;
  assign LEAD_COEF_OUT = q.lead;
  assign LAG_COEF_OUT = q.lag;
  // Weight threshold and its mode go straight to the filter
  assign WEIGHT_THRESHOLD_OUT = q.cfg[`RXT_IDX_WEIGHT_THR][6:0];
  assign WEIGHT_ABSOLUTE_OUT = q.cfg[`RXT_IDX_WEIGHT_THR][`RXT_MODE_BIT];

  // Energy detect compares against floor plus threshold or threshold
  assign energy_if.absolute = q.cfg[`RXT_IDX_ENERGY_THR][`RXT_MODE_BIT];
  assign energy_if.threshold = q.cfg[`RXT_IDX_ENERGY_THR][6:0];
  assign energy_if.floor = NOISE_FLOOR_IN;
  assign energy_if.level = ENERGY_LEVEL_IN;
  assign ENERGY_DETECT_OUT = energy_if.above;

  // Antenna search asks for strength strictly below the threshold
  assign antenna_if.absolute =
    q.cfg[`RXT_IDX_ANTENNA_THR][`RXT_MODE_BIT];
  assign antenna_if.threshold = q.cfg[`RXT_IDX_ANTENNA_THR][6:0];
  assign antenna_if.floor = NOISE_FLOOR_IN;
  assign antenna_if.level = STRENGTH_IN;
  assign ANTENNA_SEARCH_OUT = antenna_if.below;

  level_compare u_energy_cmp (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .port(energy_if.cmp)
  );

  level_compare u_antenna_cmp (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .port(antenna_if.cmp)
  );

  // Gain doubling on headroom after eight peaks
  gain_scale_check u_gain (
    .clk_in(CLOCK_IN),
    .rst_in(RESET_IN),
    .run_in(FILTER_RUN_IN),
    .peak_valid_in(PEAK_VALID_IN),
    .peak_in(PEAK_VALUE_IN),
    .threshold_in(q.cfg[`RXT_IDX_GAIN_THR]),
    .double_out(GAIN_DOUBLE_OUT)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (RESET_IN);

  sequence s_write_long;
    WR_STROBE_IN && ADDR_IN == `RXT_ADDR_LONG_SEED;
  endsequence

  sequence s_write_short;
    WR_STROBE_IN && ADDR_IN == `RXT_ADDR_SHORT_SEED;
  endsequence

  sequence s_quiet_long;
    !PREAMBLE_SHORT_IN && !WR_STROBE_IN;
  endsequence

  sequence s_quiet_short;
    PREAMBLE_SHORT_IN && !WR_STROBE_IN;
  endsequence

  property p_long_seed_used;
    (s_write_long and !PREAMBLE_SHORT_IN) ##1 s_quiet_long
      |=> SCRAMBLER_SEED_OUT == $past(WR_DATA_IN[6:0], 2);
  endproperty
  a_long_seed_used: assert property (p_long_seed_used)
    else $error("long preamble seed not delivered");

  property p_short_seed_used;
    (s_write_short and PREAMBLE_SHORT_IN) ##1 s_quiet_short
      |=> SCRAMBLER_SEED_OUT == $past(WR_DATA_IN[6:0], 2);
  endproperty
  a_short_seed_used: assert property (p_short_seed_used)
    else $error("short preamble seed not delivered");

  property p_weight_mode;
    WR_STROBE_IN && ADDR_IN == `RXT_ADDR_WEIGHT_THR
      |=> WEIGHT_ABSOLUTE_OUT == $past(WR_DATA_IN[7]) &&
          WEIGHT_THRESHOLD_OUT == $past(WR_DATA_IN[6:0]);
  endproperty
  a_weight_mode: assert property (p_weight_mode)
    else $error("weight threshold mode not applied");

  sequence s_write_then_read;
    WR_STROBE_IN && ADDR_IN == `RXT_ADDR_PRE_LEAD ##1
      RD_STROBE_IN && ADDR_IN == `RXT_ADDR_PRE_LEAD;
  endsequence

  property p_upper_bits_kept;
    s_write_then_read |=> RD_DATA_OUT == $past(WR_DATA_IN, 2);
  endproperty
  a_upper_bits_kept: assert property (p_upper_bits_kept)
    else $error("register byte not read back as written");

  property p_unmapped_zero;
    RD_STROBE_IN && !any_hit |=> RD_DATA_OUT == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero");

  property p_read_one_cycle;
    !RD_STROBE_IN |=> RD_DATA_OUT == 8'h00;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("read data held beyond its cycle");

  property p_coef_saturates;
    phase == rx_tuning_pkg::PHASE_DATA &&
      q.cfg[`RXT_IDX_DATA_LEAD][5:0] > `RXT_COEF_MAX
      |=> LEAD_COEF_OUT == `RXT_COEF_MAX;
  endproperty
  a_coef_saturates: assert property (p_coef_saturates)
    else $error("coefficient above four not saturated");

  property p_preamble_pair;
    phase == rx_tuning_pkg::PHASE_PREAMBLE &&
      q.cfg[`RXT_IDX_PRE_LEAD][5:0] <= `RXT_COEF_MAX &&
      q.cfg[`RXT_IDX_PRE_LAG][5:0] <= `RXT_COEF_MAX
      |=> LEAD_COEF_OUT == $past(q.cfg[`RXT_IDX_PRE_LEAD][5:0]) &&
          LAG_COEF_OUT == $past(q.cfg[`RXT_IDX_PRE_LAG][5:0]);
  endproperty
  a_preamble_pair: assert property (p_preamble_pair)
    else $error("preamble coefficient pair not applied");

  property p_header_pair;
    phase == rx_tuning_pkg::PHASE_HEADER &&
      q.cfg[`RXT_IDX_HDR_LEAD][5:0] <= `RXT_COEF_MAX &&
      q.cfg[`RXT_IDX_HDR_LAG][5:0] <= `RXT_COEF_MAX
      |=> LEAD_COEF_OUT == $past(q.cfg[`RXT_IDX_HDR_LEAD][5:0]) &&
          LAG_COEF_OUT == $past(q.cfg[`RXT_IDX_HDR_LAG][5:0]);
  endproperty
  a_header_pair: assert property (p_header_pair)
    else $error("header coefficient pair not applied");

  property p_data_pair;
    phase == rx_tuning_pkg::PHASE_DATA &&
      q.cfg[`RXT_IDX_DATA_LEAD][5:0] <= `RXT_COEF_MAX &&
      q.cfg[`RXT_IDX_DATA_LAG][5:0] <= `RXT_COEF_MAX
      |=> LEAD_COEF_OUT == $past(q.cfg[`RXT_IDX_DATA_LEAD][5:0]) &&
          LAG_COEF_OUT == $past(q.cfg[`RXT_IDX_DATA_LAG][5:0]);
  endproperty
  a_data_pair: assert property (p_data_pair)
    else $error("data coefficient pair not applied");

  property p_idle_holds;
    phase == rx_tuning_pkg::PHASE_IDLE |=> $stable(LEAD_COEF_OUT) &&
      $stable(LAG_COEF_OUT);
  endproperty
  a_idle_holds: assert property (p_idle_holds)
    else $error("coefficients moved while idle");

  property p_antenna_search;
    antenna_if.absolute &&
      ({1'b0, STRENGTH_IN} < {2'b00, antenna_if.threshold})
      |=> ANTENNA_SEARCH_OUT;
  endproperty
  a_antenna_search: assert property (p_antenna_search)
    else $error("antenna search not started below threshold");

  property p_energy_relative;
    !energy_if.absolute &&
      ({1'b0, ENERGY_LEVEL_IN} >=
       {1'b0, NOISE_FLOOR_IN} + {2'b00, energy_if.threshold})
      |=> ENERGY_DETECT_OUT;
  endproperty
  a_energy_relative: assert property (p_energy_relative)
    else $error("relative energy detect missed");

endmodule : rx_tuning_config_regs

`default_nettype wire

// File: src/rx_tuning_defs.svh
// Offsets, field positions, reset values and counts of the tuning bank
`ifndef RX_TUNING_DEFS_SVH
`define RX_TUNING_DEFS_SVH

// ----------------------------------------------------------------------
// Register count and byte addresses
// ----------------------------------------------------------------------
`define RXT_NUM_REGS 12
`define RXT_ADDR_WEIGHT_THR 8'h46
`define RXT_ADDR_LONG_SEED 8'h48
`define RXT_ADDR_SHORT_SEED 8'h4a
`define RXT_ADDR_ENERGY_THR 8'h4c
`define RXT_ADDR_GAIN_THR 8'h4e
`define RXT_ADDR_ANTENNA_THR 8'h50
`define RXT_ADDR_PRE_LEAD 8'h52
`define RXT_ADDR_PRE_LAG 8'h54
`define RXT_ADDR_HDR_LEAD 8'h56
`define RXT_ADDR_HDR_LAG 8'h58
`define RXT_ADDR_DATA_LEAD 8'h5a
`define RXT_ADDR_DATA_LAG 8'h5c

// ----------------------------------------------------------------------
// Storage index of each register
// ----------------------------------------------------------------------
`define RXT_IDX_WEIGHT_THR 0
`define RXT_IDX_LONG_SEED 1
`define RXT_IDX_SHORT_SEED 2
`define RXT_IDX_ENERGY_THR 3
`define RXT_IDX_GAIN_THR 4
`define RXT_IDX_ANTENNA_THR 5
`define RXT_IDX_PRE_LEAD 6
`define RXT_IDX_PRE_LAG 7
`define RXT_IDX_HDR_LEAD 8
`define RXT_IDX_HDR_LAG 9
`define RXT_IDX_DATA_LEAD 10
`define RXT_IDX_DATA_LAG 11

// ----------------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------------
`define RXT_MODE_BIT 7
`define RXT_COEF_MAX 6'h20
`define RXT_RESET_VAL 8'h00
`define RXT_LAST_PEAK 3'h7

`endif

// File: src/rx_tuning_pkg.sv
// Types shared by the receive tuning bank and its helpers
`include "rx_tuning_defs.svh"

package rx_tuning_pkg;

  // Phase of the packet being received
  typedef enum logic [1:0] {
    PHASE_PREAMBLE,
    PHASE_HEADER,
    PHASE_DATA,
    PHASE_IDLE
  } packet_phase_e;

  // Gain scaling decision steps
  typedef enum logic [1:0] {
    GAIN_IDLE,
    GAIN_ACCUM,
    GAIN_DONE
  } gain_state_e;

  typedef struct packed {
    logic [`RXT_NUM_REGS-1:0][7:0] cfg;
    logic [7:0] rd_data;
    logic [6:0] seed;
    logic [5:0] lead;
    logic [5:0] lag;
  } cfg_state_s;

  typedef struct packed {
    gain_state_e st;
    logic [2:0] count;
    logic [10:0] sum;
    logic double_gain;
  } gain_state_s;

  typedef struct packed {
    logic above;
    logic below;
  } cmp_state_s;

endpackage : rx_tuning_pkg
